// ===== hdl/pmo_mic.sv
`default_nettype none
module pmo_mic #(
  parameter int WIDTH = pmo_pkg::SAMPLE_WIDTH,
  parameter int DEPTH = pmo_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic falling_variant,
  input wire logic pdm_clk,
  output logic pdm_data_out,
  output logic pdm_data_oe,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [WIDTH-1:0] sample_data,
  output logic underrun
);
  import pmo_pkg::*;
  localparam int AW = WIDTH + 2; // Integrator headroom
  localparam int RW = $clog2(OVERSAMPLING_RATIO);
  localparam logic [RW-1:0] RATIO_LAST = RW'(OVERSAMPLING_RATIO - 1);
  localparam int GW = $clog2(GUARD_CYC + 1);
  localparam logic [GW-1:0] GUARD_LAST = GW'(GUARD_CYC);
  localparam logic signed [AW-1:0] FULL_SCALE = AW'(1) <<< (WIDTH - 1);

  // ==========================================================
  // Buffer in the sample path
  // ==========================================================
  pmo_stream_if #(.WIDTH(WIDTH)) feed ();

  pmo_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out(feed.src)
  );

  // ==========================================================
  // Variant strap, caught once after reset release
  // ==========================================================
  logic strap_taken; // Strap has been sampled
  logic use_falling; // Held variant: 1 drives after falling edge

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
      use_falling <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      use_falling <= falling_variant;
    end
  end

  // ==========================================================
  // Microphone clock edges
  // ==========================================================
  logic clk_prev; // Pin level one cycle back
  // Edges are ignored until the variant is known
  wire rise = strap_taken && pdm_clk && !clk_prev;
  wire fall = strap_taken && !pdm_clk && clk_prev;
  wire own_edge = use_falling ? fall : rise;
  wire other_edge = use_falling ? rise : fall;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) clk_prev <= 1'b0;
    else clk_prev <= pdm_clk;
  end

  // ==========================================================
  // Sample pacing: one word per oversampling period
  // ==========================================================
  logic [RW-1:0] ratio_cnt; // Own edges within the period
  logic signed [WIDTH-1:0] cur_sample; // Input held for the period
  wire period_end = own_edge && (ratio_cnt == RATIO_LAST);
  assign feed.ready = period_end;

  // A missing word keeps the old one, so the output stays coherent
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ratio_cnt <= '0;
      cur_sample <= '0;
      underrun <= 1'b0;
    end else begin
      if (own_edge) begin
        ratio_cnt <= period_end ? '0 : ratio_cnt + RW'(1);
      end
      if (period_end && feed.valid) cur_sample <= feed.data;
      if (period_end) underrun <= !feed.valid;
    end
  end

  // ==========================================================
  // First-order sigma-delta modulator
  // ==========================================================
  logic signed [AW-1:0] acc; // Integrator
  logic signed [AW-1:0] next_acc;
  wire mod_bit = !acc[AW-1]; // One while integrator is non-negative
  wire signed [AW-1:0] feedback = mod_bit ? FULL_SCALE : -FULL_SCALE;

  // Zero input alternates ones and zeros, full scale saturates
  assign next_acc = acc + AW'(cur_sample) - feedback;

  // ==========================================================
  // Data pin driver
  // ==========================================================
  pmo_drive_type drv; // Driver phase
  logic [GW-1:0] guard_cnt; // Cycles waited since own edge

  // Release happens at the partner's edge; own drive waits out a guard
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drv <= DRV_IDLE;
      guard_cnt <= '0;
      acc <= '0;
      pdm_data_out <= PIN_RESET;
      pdm_data_oe <= 1'b0;
    end else begin
      if (own_edge) begin
        // Exactly one new bit per microphone cycle
        acc <= next_acc;
        pdm_data_out <= mod_bit;
      end
      case (drv)
        DRV_IDLE: begin
          if (own_edge) begin
            drv <= DRV_GUARD;
            guard_cnt <= GW'(1);
          end
        end
        DRV_GUARD: begin
          if (other_edge) begin
            drv <= DRV_IDLE;
          end else if (guard_cnt == GUARD_LAST) begin
            drv <= DRV_ON;
            pdm_data_oe <= 1'b1;
          end else begin
            guard_cnt <= guard_cnt + GW'(1);
          end
        end
        DRV_ON: begin
          if (other_edge) begin
            drv <= DRV_IDLE;
            pdm_data_oe <= 1'b0;
          end
        end
        default: begin
          drv <= DRV_IDLE;
          pdm_data_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  localparam int RATIO_M1 = OVERSAMPLING_RATIO - 1;
  logic [7:0] edges_since; // Own edges since the last period end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) edges_since <= '0;
    else if (period_end) edges_since <= '0;
    else if (own_edge) edges_since <= edges_since + 8'h01;
  end

  sequence s_own_then_quiet;
    own_edge ##1 !other_edge [*3];
  endsequence

  property p_bit_only_on_edge;
    @(posedge clk_sys) disable iff (!nrst)
      !$past(own_edge) |-> $stable(pdm_data_out);
  endproperty
  a_bit_only_on_edge: assert property (p_bit_only_on_edge)
    else $error("data bit changed without an own clock edge");

  property p_bit_from_integrator;
    @(posedge clk_sys) disable iff (!nrst)
      own_edge |=> pdm_data_out == !$past(acc[AW-1]);
  endproperty
  a_bit_from_integrator: assert property (p_bit_from_integrator)
    else $error("data bit does not follow integrator sign");

  property p_word_per_ratio;
    @(posedge clk_sys) disable iff (!nrst)
      period_end |-> edges_since == 8'(RATIO_M1);
  endproperty
  a_word_per_ratio: assert property (p_word_per_ratio)
    else $error("sample taken at wrong oversampling count");

  property p_half_cycle_release;
    @(posedge clk_sys) disable iff (!nrst)
      other_edge |=> !pdm_data_oe;
  endproperty
  a_half_cycle_release: assert property (p_half_cycle_release)
    else $error("data still driven in the partner half");

  property p_guard_before_drive;
    @(posedge clk_sys) disable iff (!nrst)
      s_own_then_quiet |-> $rose(pdm_data_oe);
  endproperty
  a_guard_before_drive: assert property (p_guard_before_drive)
    else $error("drive did not start exactly after the guard");

  property p_drive_after_own_edge;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(pdm_data_oe) |-> $past(own_edge, 3);
  endproperty
  a_drive_after_own_edge: assert property (p_drive_after_own_edge)
    else $error("drive began without the variant's own edge");
endmodule
`default_nettype wire

// ===== hdl/pmo_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants of the stereo PDM microphone output
// ==========================================================
package pmo_pkg;
  // Sample and buffer shape
  localparam int SAMPLE_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  // Modulator: oversampling ratio and band edge divisor
  localparam int OVERSAMPLING_RATIO = 60;
  localparam int BAND_DIVISOR = 2 * OVERSAMPLING_RATIO;
  // System clock period in ns
  localparam int SYS_PERIOD_NS = 4;
  // Least dead time between release and own drive, in ns
  localparam int GUARD_NS = 8;
  // Rounded up to whole cycles, at least one
  localparam int GUARD_CYC_RAW = (GUARD_NS + SYS_PERIOD_NS - 1) /
                                 SYS_PERIOD_NS;
  localparam int GUARD_CYC = (GUARD_CYC_RAW < 1) ? 1 : GUARD_CYC_RAW;
  // Reset values
  localparam logic PIN_RESET = 1'b0;
  // Driver phases of the data pin
  typedef enum logic [1:0] {
    DRV_IDLE,
    DRV_GUARD,
    DRV_ON
  } pmo_drive_type;
endpackage
`default_nettype wire

// ===== hdl/pmo_stream_if.sv
`default_nettype none
// ==========================================================
// Valid/ready word stream between buffer and modulator
// ==========================================================
interface pmo_stream_if #(
  parameter int WIDTH = 16
);
  logic valid; // Word on data is offered
  logic ready; // Word is taken this cycle
  logic [WIDTH-1:0] data; // Offered word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== hdl/pmo_fifo.sv
`default_nettype none
// ==========================================================
// Sample buffer
// ==========================================================
module pmo_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  pmo_stream_if.src out
);
  import pmo_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr; // Next slot to fill
  logic [AW-1:0] rd_ptr; // Oldest stored slot
  logic [CW-1:0] count; // Words held
  logic [CW-1:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out.valid && out.ready;

  // Pointer step with wrap, for depths that are not powers of two
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == LAST) ? '0 : p + AW'(1);
  endfunction

  // ==========================================================
  // Occupancy
  // ==========================================================
  assign next_count = count + CW'(push) - CW'(pop);
  assign out.valid = (count != '0);
  assign out.data = mem[rd_ptr];

  // Ready is a flop so that the top sees it straight from a register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      in_ready <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      count <= next_count;
      in_ready <= (next_count < FULL);
      if (push) wr_ptr <= step(wr_ptr);
      if (pop) rd_ptr <= step(rd_ptr);
    end
  end

  // Storage has no reset; only pushed words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule
`default_nettype wire

// ===== test/pmo_host_model.sv
`default_nettype none
// ==========================================
// Host side: clock source, edge latch, counts
// ==========================================
module pmo_host_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  input wire logic clear,
  input wire logic line,
  output logic pdm_clk,
  output logic [15:0] ones_r,
  output logic [15:0] ones_f,
  output logic [15:0] bits_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] tick; // Half period of 6 cycles
  logic seen; // A falling edge has passed
  logic flip; // Clock toggles this cycle
  // Halts low between runs, so a high half is always finished
  assign flip = (tick == 3'h5) && (run || pdm_clk);
  // Latch each channel at the edge that ends its half; counting ones is
  // a crude decimator, enough to judge density
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick <= 3'h0;
      pdm_clk <= 1'b0;
      seen <= 1'b0;
      ones_r <= 16'h0;
      ones_f <= 16'h0;
      bits_r <= 16'h0;
    end else begin
      tick <= (tick == 3'h5) ? 3'h0 : tick + 3'h1;
      if (clear) begin
        ones_r <= 16'h0;
        ones_f <= 16'h0;
        bits_r <= 16'h0;
      end else if (flip && pdm_clk) begin
        ones_r <= ones_r + {15'h0, line};
        bits_r <= bits_r + 16'h1;
      end else if (flip && seen) begin
        ones_f <= ones_f + {15'h0, line};
      end
      if (flip) begin
        pdm_clk <= !pdm_clk;
        seen <= seen | pdm_clk;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/test_pmo_mic.sv
`default_nettype none
// ==========================================
// Stereo pair on one shared clock and data line
// ==========================================
module test_pmo_mic;
  timeunit 1ns;
  timeprecision 1ns;
  import pmo_pkg::*;
  logic clk_sys, nrst, s_valid, run, clear, line, pdm_clk;
  logic filler = 1'b0; // Idle pattern of the released line
  logic pclk_q = 1'b0; // Host clock one cycle back
  logic [15:0] s_data, ones_r, ones_f, bits_r;
  logic [15:0] overlap = 16'h0; // Cycles with both drivers on
  logic [1:0] dout, oe, rdy, und; // Index 0 rising, 1 falling variant
  int rises = 0; // Host clock rises seen
  int failures, n_tests;
  // Released line toggles each cycle, so a stale bit never looks valid
  assign line = oe[0] ? dout[0] : (oe[1] ? dout[1] : filler);
  pmo_mic pmo_mic_inst[1:0] (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .falling_variant(2'b10),
    .pdm_clk(pdm_clk),
    .pdm_data_out(dout),
    .pdm_data_oe(oe),
    .sample_valid(s_valid),
    .sample_ready(rdy),
    .sample_data(s_data),
    .underrun(und)
  );
  pmo_host_model pmo_host_model_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(run),
    .clear(clear),
    .line(line),
    .pdm_clk(pdm_clk),
    .ones_r(ones_r),
    .ones_f(ones_f),
    .bits_r(bits_r)
  );
  // Count host clock rises and cycles with both drivers on
  always @(posedge clk_sys) begin
    filler <= !filler;
    pclk_q <= pdm_clk;
    if (pdm_clk && !pclk_q) rises <= rises + 1;
    if (oe === 2'b11) overlap <= overlap + 16'h1;
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  // Watchdog against any hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    stall();
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stall;
    failures++;
    give_verdict();
  endtask
  // Offer one word and hold it until both sides take it
  task automatic push(input logic [15:0] d);
    int i;
    @(posedge clk_sys);
    s_valid <= 1'b1;
    s_data <= d;
    for (i = 0; i < 2000; i++) begin
      #1;
      if (rdy === 2'b11) break;
      @(posedge clk_sys);
    end
    if (i == 2000) stall();
    @(posedge clk_sys);
    s_valid <= 1'b0;
  endtask
  // Clear the host counts, run n clock periods, halt low
  task automatic cycles(input int n);
    int i, goal;
    @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    run <= 1'b1;
    goal = rises + n;
    for (i = 0; i < 16 * n + 32 && rises < goal; i++) @(posedge clk_sys);
    run <= 1'b0;
    if (rises < goal) stall();
    repeat (16) @(posedge clk_sys);
  endtask
  // Outputs quiet while reset is held 16 cycles, then release
  task automatic test_reset;
    repeat (16) @(posedge clk_sys);
    chk("oe in reset", 16'h0, {14'h0, oe});
    chk("ready in reset", 16'h0, {14'h0, rdy});
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    $display("test reset done");
  endtask
  // Fill the buffer, then a ninth word must be refused
  task automatic test_fill;
    repeat (8) push(16'h0);
    @(posedge clk_sys);
    s_valid <= 1'b1;
    s_data <= 16'h7fff;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("ready when full", 16'h0, {14'h0, rdy});
    @(posedge clk_sys);
    s_valid <= 1'b0;
    $display("test fill done");
  endtask
  // Zero input from reset gives 1,0,1,0 on both channels
  task automatic test_zero;
    cycles(40);
    chk("bits rising", 16'h28, bits_r);
    chk("ones rising", 16'h14, ones_r);
    chk("ones falling", 16'h14, ones_f);
    chk("overlap", 16'h0, overlap);
    $display("test zero done");
  endtask
  // One word is drawn every 60 own edges
  task automatic test_period;
    cycles(20);
    chk("pop at 60", 16'h3, {14'h0, rdy});
    push(16'h0);
    cycles(59);
    chk("no pop at 59", 16'h0, {14'h0, rdy});
    cycles(1);
    chk("pop at 120", 16'h3, {14'h0, rdy});
    $display("test period done");
  endtask
  // Drain to underrun, then full-scale words at both ends
  task automatic test_scale;
    cycles(500);
    chk("underrun drained", 16'h3, {14'h0, und});
    repeat (3) push(16'h8000);
    repeat (3) push(16'h7fff);
    cycles(60);
    chk("underrun cleared", 16'h0, {14'h0, und});
    cycles(100);
    chk("low r", 16'h1, {15'h0, ones_r < 16'ha});
    chk("low f", 16'h1, {15'h0, ones_f < 16'ha});
    cycles(140);
    cycles(100);
    chk("high r", 16'h1, {15'h0, ones_r > 16'h5a});
    chk("high f", 16'h1, {15'h0, ones_f > 16'h5a});
    cycles(120);
    chk("underrun again", 16'h3, {14'h0, und});
    chk("overlap end", 16'h0, overlap);
    $display("test scale done");
  endtask
  initial begin
    nrst = 1'b0;
    s_valid = 1'b0;
    s_data = 16'h0;
    run = 1'b0;
    clear = 1'b0;
    failures = 0;
    n_tests = 0;
    test_reset();
    test_fill();
    test_zero();
    test_period();
    test_scale();
    give_verdict();
  end
endmodule
`default_nettype wire
